// ### hdl/fsg_ext_sync.sv
// Pin selector and two-flop synchroniser for the external trigger source
`timescale 1ns/10ps
`default_nettype none
module fsg_ext_sync (
    input wire logic clk, // Core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [2:0] pin_sel, // General-purpose pin index
    input wire logic [7:0] gpio_in, // General-purpose pin levels
    output logic ext_level // Synchronised level of the chosen pin
);
    typedef struct packed {
        logic meta;
        logic sync;
    } fsg_sync_t;

    fsg_sync_t r;
    fsg_sync_t n;
    logic picked;

    // The pin may be asynchronous to us, so only the second flop is read
    always_comb begin
        picked = gpio_in[pin_sel];
        n.meta = picked;
        n.sync = r.meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign ext_level = r.sync;

    a_sync_delay: assert property (@(posedge clk) disable iff (srst)
        (!$past(srst) && !$past(srst, 2) && $past(pin_sel) == $past(pin_sel, 2))
        |-> ext_level == $past(picked, 2))
        else $error("external level is not the chosen pin two cycles late");
endmodule
`default_nettype wire

// ### hdl/fsg_pkg.sv
// Shared constants and types of the frame sync generator
`default_nettype none
package fsg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTL = 6'h18;
    localparam logic [5:0] IDX_HU = 6'h19;
    localparam logic [5:0] IDX_HL = 6'h1A;
    localparam logic [5:0] IDX_LU = 6'h1B;
    localparam logic [5:0] IDX_LL = 6'h1C;
    localparam logic [5:0] IDX_STAT = 6'h20;

    // Control register field positions
    localparam int unsigned CTL_SRC_HI = 7;
    localparam int unsigned CTL_SRC_LO = 4;
    localparam int unsigned CTL_SHOT = 3;
    localparam int unsigned CTL_IDLE = 2;
    localparam int unsigned CTL_SCHEME = 1;
    localparam int unsigned CTL_ON = 0;

    // Source code bits: bit 3 selects a pin, bit 2 the reference clock
    localparam int unsigned SRC_EXT_BIT = 3;
    localparam int unsigned SRC_REF_BIT = 2;

    // Status register field positions
    localparam int unsigned STAT_LEVEL = 0;
    localparam int unsigned STAT_RUN = 1;
    localparam int unsigned STAT_SHOT = 2;

    // Reset values
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'h00;

    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Width of the phase counter
    localparam int unsigned CNT_W = 24;

    typedef enum logic [1:0] {FSG_IDLE, FSG_HIGH, FSG_LOW, FSG_SHOT} fsg_state_t;
endpackage
`default_nettype wire

// ### hdl/fsg_tick_sel.sv
// Timing clock selector producing one tick per rising edge of the chosen clock
`timescale 1ns/10ps
`default_nettype none
module fsg_tick_sel (
    input wire logic clk, // Core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [3:0] src_sel, // Source code, internal modes only matter
    input wire logic [3:0] frame_clk_port, // Back-channel frame clocks of ports 0..3
    input wire logic ref_clk_25m, // Reference clock level
    output logic tick // One-cycle pulse per rising edge
);
    typedef struct packed {
        logic lvl;
        logic prev;
    } fsg_tick_t;

    fsg_tick_t r;
    fsg_tick_t n;
    logic picked;

    // Codes 01xx take the reference clock, 00nn the frame clock of port nn
    always_comb begin
        picked = src_sel[fsg_pkg::SRC_REF_BIT] ? ref_clk_25m
            : frame_clk_port[src_sel[1:0]];
        n.lvl = picked;
        n.prev = r.lvl;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Edge of the chosen clock, from flops only
    assign tick = r.lvl & ~r.prev;

    a_tick_source: assert property (@(posedge clk) disable iff (srst)
        (tick && !$past(srst)) |-> ($past(picked) && !$past(r.lvl)))
        else $error("tick without a rising edge of the selected clock");
endmodule
`default_nettype wire

// ### hdl/fsg_top.sv
// Frame sync generator: register slave, source selection and phase timing
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Source codes 0000 to 0011 time the generator from frame clock of port 0-3.
// - Source codes 01xx time the generator from the 25 MHz reference clock.
// - Source codes 1000 to 1111 pass general-purpose pin 0 to 7 through.
// - Writing one to control bit 3 with bit 0 at zero in a timed mode emits one pulse; the bit reads zero.
// - Control bit 2 sets the starting and resting trigger level.
// - Scheme bit 1 at zero times high and low from separate 16-bit counts.
// - Scheme bit 1 at one uses one 24-bit count for both phases.
// - Control bit 0 starts periodic generation, clearing stops it; resets to zero.
// - High upper register holds bits 15:8 of the high count under scheme 0, unused under scheme 1; resets zero.
// - Each phase lasts the programmed count plus one timing ticks.
// - High lower register holds bits 7:0 of the high count under scheme 0, bits 23:16 of the shared count under scheme 1.
// - Under scheme 0 the low count is split into upper and lower bytes, both reset zero.
module fsg_top (
    input wire logic clk, // Core clock, 50 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready, always high
    output logic hresp, // Response, always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic [3:0] frame_clk_port, // Back-channel frame clocks
    input wire logic ref_clk_25m, // Reference clock level
    input wire logic [7:0] gpio_in, // General-purpose pin levels
    output logic camera_trigger // Trigger output
);
    typedef struct packed {
        logic [3:0] src;
        logic idle_lvl;
        logic scheme;
        logic on;
        logic [7:0] hu;
        logic [7:0] hl;
        logic [7:0] lu;
        logic [7:0] ll;
        logic shot_req;
        logic shot_wait;
        fsg_pkg::fsg_state_t st;
        logic [fsg_pkg::CNT_W-1:0] cnt;
        logic trig;
        logic ap_valid;
        logic ap_write;
        logic [5:0] ap_idx;
        logic rdy;
        logic resp;
        logic [31:0] rdata;
    } fsg_regs_t;

    fsg_regs_t r;
    fsg_regs_t n;
    logic tick;
    logic ext_level;
    logic ext_mode;
    logic word_ok;
    logic [fsg_pkg::CNT_W-1:0] len_hi;
    logic [fsg_pkg::CNT_W-1:0] len_lo;
    logic [fsg_pkg::CNT_W-1:0] len_shot;

    // Phase length from the period bytes under the selected scheme
    function automatic logic [fsg_pkg::CNT_W-1:0] phase_len(
        input logic high,
        input logic scheme,
        input logic [7:0] hu,
        input logic [7:0] hl,
        input logic [7:0] lu,
        input logic [7:0] ll
    );
        if (scheme) begin
            phase_len = {hl, lu, ll};
        end else if (high) begin
            phase_len = {8'h00, hu, hl};
        end else begin
            phase_len = {8'h00, lu, ll};
        end
    endfunction

    // Register read mux; unmapped words read as zero
    function automatic logic [31:0] read_word(input logic [5:0] idx, input fsg_regs_t s);
        read_word = 32'h0000_0000;
        if (idx == fsg_pkg::IDX_CTL) begin
            read_word[7:0] = {s.src, 1'b0, s.idle_lvl, s.scheme, s.on};
        end else if (idx == fsg_pkg::IDX_HU) begin
            read_word[7:0] = s.hu;
        end else if (idx == fsg_pkg::IDX_HL) begin
            read_word[7:0] = s.hl;
        end else if (idx == fsg_pkg::IDX_LU) begin
            read_word[7:0] = s.lu;
        end else if (idx == fsg_pkg::IDX_LL) begin
            read_word[7:0] = s.ll;
        end else if (idx == fsg_pkg::IDX_STAT) begin
            read_word[fsg_pkg::STAT_LEVEL] = s.trig;
            read_word[fsg_pkg::STAT_RUN] = (s.st == fsg_pkg::FSG_HIGH) || (s.st == fsg_pkg::FSG_LOW);
            read_word[fsg_pkg::STAT_SHOT] = (s.st == fsg_pkg::FSG_SHOT) || s.shot_wait;
        end
    endfunction

    // Timing tick from the selected internal clock
    fsg_tick_sel u_tick (
        .clk(clk),
        .srst(srst),
        .src_sel(r.src),
        .frame_clk_port(frame_clk_port),
        .ref_clk_25m(ref_clk_25m),
        .tick(tick)
    );

    // Synchronised external trigger pin
    fsg_ext_sync u_ext (
        .clk(clk),
        .srst(srst),
        .pin_sel(r.src[2:0]),
        .gpio_in(gpio_in),
        .ext_level(ext_level)
    );

    // Decoded lengths and mode
    assign ext_mode = r.src[fsg_pkg::SRC_EXT_BIT];
    assign len_hi = phase_len(1'b1, r.scheme, r.hu, r.hl, r.lu, r.ll);
    assign len_lo = phase_len(1'b0, r.scheme, r.hu, r.hl, r.lu, r.ll);
    assign len_shot = r.idle_lvl ? len_lo : len_hi;
    assign word_ok = hsel && hready && htrans[1] && (hsize == fsg_pkg::HSIZE_WORD)
        && (haddr[1:0] == 2'h0) && (haddr[31:8] == 24'h00_0000);

    // Next state: bus writes, generator sequencing, then the read answer
    always_comb begin
        n = r;
        n.shot_req = 1'b0;
        n.rdy = 1'b1;
        n.resp = fsg_pkg::HRESP_OKAY;
        // Data phase of a write lands here
        if (r.ap_valid && r.ap_write) begin
            if (r.ap_idx == fsg_pkg::IDX_CTL) begin
                n.src = hwdata[fsg_pkg::CTL_SRC_HI:fsg_pkg::CTL_SRC_LO];
                n.idle_lvl = hwdata[fsg_pkg::CTL_IDLE];
                n.scheme = hwdata[fsg_pkg::CTL_SCHEME];
                n.on = hwdata[fsg_pkg::CTL_ON];
                n.shot_req = hwdata[fsg_pkg::CTL_SHOT];
            end else if (r.ap_idx == fsg_pkg::IDX_HU) begin
                n.hu = hwdata[7:0];
            end else if (r.ap_idx == fsg_pkg::IDX_HL) begin
                n.hl = hwdata[7:0];
            end else if (r.ap_idx == fsg_pkg::IDX_LU) begin
                n.lu = hwdata[7:0];
            end else if (r.ap_idx == fsg_pkg::IDX_LL) begin
                n.ll = hwdata[7:0];
            end
        end
        // Generator; a phase ends on the tick that finds the count reached
        case (r.st)
            fsg_pkg::FSG_IDLE: begin
                n.cnt = '0;
                // Phases open on a tick, so even the first one is whole ticks long
                if (r.on) begin
                    n.shot_wait = 1'b0;
                    if (tick) begin
                        n.st = r.idle_lvl ? fsg_pkg::FSG_HIGH : fsg_pkg::FSG_LOW;
                    end
                end else if ((r.shot_req || r.shot_wait) && tick) begin
                    n.st = fsg_pkg::FSG_SHOT;
                    n.shot_wait = 1'b0;
                end else if (r.shot_req) begin
                    n.shot_wait = 1'b1;
                end
            end
            fsg_pkg::FSG_HIGH: begin
                if (!r.on) begin
                    n.st = fsg_pkg::FSG_IDLE;
                end else if (tick && r.cnt >= len_hi) begin
                    n.st = fsg_pkg::FSG_LOW;
                    n.cnt = '0;
                end else if (tick) begin
                    n.cnt = r.cnt + 1'b1;
                end
            end
            fsg_pkg::FSG_LOW: begin
                if (!r.on) begin
                    n.st = fsg_pkg::FSG_IDLE;
                end else if (tick && r.cnt >= len_lo) begin
                    n.st = fsg_pkg::FSG_HIGH;
                    n.cnt = '0;
                end else if (tick) begin
                    n.cnt = r.cnt + 1'b1;
                end
            end
            default: begin
                // Further requests are dropped until the pulse ends
                if (tick && r.cnt >= len_shot) begin
                    n.st = fsg_pkg::FSG_IDLE;
                    n.cnt = '0;
                end else if (tick) begin
                    n.cnt = r.cnt + 1'b1;
                end
            end
        endcase
        // Pin modes bypass the counters entirely
        if (ext_mode) begin
            n.st = fsg_pkg::FSG_IDLE;
            n.cnt = '0;
            n.shot_wait = 1'b0;
            n.trig = ext_level;
        end else if (n.st == fsg_pkg::FSG_HIGH) begin
            n.trig = 1'b1;
        end else if (n.st == fsg_pkg::FSG_LOW) begin
            n.trig = 1'b0;
        end else if (n.st == fsg_pkg::FSG_SHOT) begin
            n.trig = ~r.idle_lvl;
        end else begin
            n.trig = r.idle_lvl;
        end
        // Address phase; read data taken from next values so a write just
        // before a read of the same word is seen without a wait state
        n.ap_valid = word_ok;
        n.ap_write = hwrite;
        n.ap_idx = haddr[7:2];
        n.rdata = (word_ok && !hwrite) ? read_word(haddr[7:2], n) : 32'h0000_0000;
    end

    // State register with documented reset values
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.src <= fsg_pkg::RST_CTL[fsg_pkg::CTL_SRC_HI:fsg_pkg::CTL_SRC_LO];
            r.idle_lvl <= fsg_pkg::RST_CTL[fsg_pkg::CTL_IDLE];
            r.scheme <= fsg_pkg::RST_CTL[fsg_pkg::CTL_SCHEME];
            r.on <= fsg_pkg::RST_CTL[fsg_pkg::CTL_ON];
            r.hu <= fsg_pkg::RST_PERIOD;
            r.hl <= fsg_pkg::RST_PERIOD;
            r.lu <= fsg_pkg::RST_PERIOD;
            r.ll <= fsg_pkg::RST_PERIOD;
            r.rdy <= 1'b1;
            r.resp <= fsg_pkg::HRESP_OKAY;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign camera_trigger = r.trig;
    assign hrdata = r.rdata;
    assign hreadyout = r.rdy;
    assign hresp = r.resp;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_ext_follow: assert property (
        (ext_mode && !$past(srst)) |=> (r.trig == $past(ext_level)))
        else $error("trigger does not follow the synchronised pin");

    a_idle_level: assert property (
        (r.st == fsg_pkg::FSG_IDLE && !ext_mode && !r.on && !r.shot_req && !r.shot_wait)
        |=> (r.trig == $past(r.idle_lvl)))
        else $error("resting trigger level differs from the idle control");

    a_gen_stop: assert property (
        (!r.on && !ext_mode && (r.st == fsg_pkg::FSG_HIGH || r.st == fsg_pkg::FSG_LOW))
        |=> (r.st == fsg_pkg::FSG_IDLE))
        else $error("generator kept running after being disabled");

    a_shot_start: assert property (
        (r.st == fsg_pkg::FSG_IDLE && (r.shot_req || r.shot_wait) && tick
            && !r.on && !ext_mode)
        |=> (r.st == fsg_pkg::FSG_SHOT && r.trig != $past(r.idle_lvl)))
        else $error("single pulse request did not start a pulse");

    a_shot_reads: assert property (
        ($past(word_ok) && !$past(hwrite) && $past(haddr[7:2]) == fsg_pkg::IDX_CTL)
        |-> !hrdata[fsg_pkg::CTL_SHOT])
        else $error("single pulse bit read back as one");

    a_high_end: assert property (
        ($past(r.st) == fsg_pkg::FSG_HIGH && r.st == fsg_pkg::FSG_LOW && !$past(ext_mode))
        |-> ($past(tick) && $past(r.cnt) >= $past(len_hi)))
        else $error("high phase ended before its count");

    a_low_end: assert property (
        ($past(r.st) == fsg_pkg::FSG_LOW && r.st == fsg_pkg::FSG_HIGH && !$past(ext_mode))
        |-> ($past(tick) && $past(r.cnt) >= $past(len_lo)))
        else $error("low phase ended before its count");

    a_fifty_len: assert property (
        r.scheme |-> (len_hi == {r.hl, r.lu, r.ll} && len_lo == len_hi))
        else $error("shared count not used for both phases");

    a_split_len: assert property (
        !r.scheme |-> (len_hi == {8'h00, r.hu, r.hl} && len_lo == {8'h00, r.lu, r.ll}))
        else $error("separate counts not built from their bytes");

    a_upper_write: assert property (
        (r.ap_valid && r.ap_write && r.ap_idx == fsg_pkg::IDX_HU)
        |=> (r.hu == $past(hwdata[7:0])))
        else $error("high upper byte not stored");
endmodule
`default_nettype wire

// ### verif/fsg_partner.sv
// Far-side model: makes the timing clocks and measures trigger phases
`timescale 1ns/10ps
`default_nettype none
module fsg_partner (
    input wire logic clk, // Core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic camera_trigger, // Trigger seen by the remote sensors
    output logic ref_clk_25m, // Reference clock, one core cycle per level
    output logic [3:0] frame_clk_port, // Port n clock toggles every n+2 cycles
    output logic [31:0] hi_len, // Cycles of the last finished high phase
    output logic [31:0] lo_len, // Cycles of the last finished low phase
    output logic [31:0] edge_count // Trigger level changes seen
);
    logic [31:0] cyc = 32'h0;
    logic [31:0] run_len;
    logic last;
    initial begin
        ref_clk_25m = 1'b0;
        frame_clk_port = 4'h0;
    end
    // Distinct periods per port, so a wrong port decode shows as a wrong length
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        ref_clk_25m <= srst ? 1'b0 : ~ref_clk_25m;
        for (int n = 0; n < 4; n++) begin
            frame_clk_port[n] <= 1'(((cyc + 32'h1) / 32'(n + 2)) % 32'h2);
        end
    end
    // Run length of each level, stored when the level changes
    always @(posedge clk) begin
        if (srst) begin
            edge_count <= 32'h0;
            run_len <= 32'h1;
            last <= 1'b0;
        end else if (camera_trigger !== last) begin
            if (last) begin
                hi_len <= run_len;
            end else begin
                lo_len <= run_len;
            end
            edge_count <= edge_count + 32'h1;
            run_len <= 32'h1;
            last <= camera_trigger;
        end else begin
            run_len <= run_len + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench of the frame sync generator
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, srst, hsel, hwrite, hreadyout, hresp, camera_trigger, ref_clk_25m;
    logic [31:0] haddr, hwdata, hrdata, hi_len, lo_len, edge_count, rng, q, st;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] frame_clk_port;
    logic [7:0] gpio_in;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [5:0] REGS [5] = '{fsg_pkg::IDX_CTL, fsg_pkg::IDX_HU, fsg_pkg::IDX_HL,
        fsg_pkg::IDX_LU, fsg_pkg::IDX_LL};
    fsg_top fsg_top_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_clk_port(frame_clk_port),
        .ref_clk_25m(ref_clk_25m), .gpio_in(gpio_in), .camera_trigger(camera_trigger));
    fsg_partner fsg_partner_inst (.clk(clk), .srst(srst), .camera_trigger(camera_trigger),
        .ref_clk_25m(ref_clk_25m), .frame_clk_port(frame_clk_port), .hi_len(hi_len),
        .lo_len(lo_len), .edge_count(edge_count));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // Phase length in cycles for a count and a tick period
    function automatic logic [31:0] plen(input logic [23:0] c, input logic [31:0] per);
        return (32'(c) + 32'h1) * per;
    endfunction
    // One AHB single transfer; the address phase holds until hready is seen
    task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
        chk("response", {31'h0, hresp}, 32'h0);
    endtask
    task automatic wait_edges(input int n);
        st = edge_count;
        while (edge_count < st + 32'(n)) @(posedge clk);
    endtask
    // Program counts, run the generator, measure full phases, then stop it
    task automatic gen_case(input logic [3:0] src, input logic sch, input logic [7:0] hu,
        input logic [7:0] hl, input logic [7:0] lu, input logic [7:0] ll, input int per);
        logic [23:0] hc;
        logic [23:0] lc;
        hc = sch ? {hl, lu, ll} : {8'h0, hu, hl};
        lc = sch ? {hl, lu, ll} : {8'h0, lu, ll};
        xfer(fsg_pkg::IDX_HU, 1'b1, hu);
        xfer(fsg_pkg::IDX_HL, 1'b1, hl);
        xfer(fsg_pkg::IDX_LU, 1'b1, lu);
        xfer(fsg_pkg::IDX_LL, 1'b1, ll);
        xfer(fsg_pkg::IDX_CTL, 1'b1, {src, 2'h0, sch, 1'b1});
        wait_edges(4);
        chk("high phase", hi_len, plen(hc, 32'(per)));
        chk("low phase", lo_len, plen(lc, 32'(per)));
        xfer(fsg_pkg::IDX_STAT, 1'b0, 8'h0);
        chk("running", {31'h0, q[fsg_pkg::STAT_RUN]}, 32'h1);
        xfer(fsg_pkg::IDX_CTL, 1'b1, {src, 4'h0});
        repeat (3) @(posedge clk);
        st = edge_count;
        repeat (3 * per) @(posedge clk);
        chk("stopped", edge_count, st);
        $display("test generator source %h scheme %b done", src, sch);
    endtask
    // Single pulse with the given idle level and count; no second request until it ends
    task automatic shot(input logic idle, input logic [7:0] k);
        xfer(idle ? fsg_pkg::IDX_LL : fsg_pkg::IDX_HL, 1'b1, k);
        st = edge_count;
        xfer(fsg_pkg::IDX_CTL, 1'b1, {4'h4, 1'b1, idle, 2'h0});
        repeat (2 * 32'(k) + 20) @(posedge clk);
        chk("pulse edges", edge_count, st + 32'h2);
        chk("pulse length", idle ? lo_len : hi_len, plen(24'(k), 32'h2));
        xfer(fsg_pkg::IDX_CTL, 1'b0, 8'h0);
        chk("control after pulse", q, {24'h0, 4'h4, 1'b0, idle, 2'h0});
        $display("test single pulse idle %b done", idle);
    endtask
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = fsg_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        gpio_in = 8'h00;
        rng = 32'h21;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // Reset values, then random read-back of the count bytes
        for (int i = 0; i < 5; i++) begin
            xfer(REGS[i], 1'b0, 8'h0);
            chk("reset value", q, 32'h0);
        end
        chk("idle trigger", {31'h0, camera_trigger}, 32'h0);
        for (int i = 1; i < 5; i++) begin
            rng = xorshift(rng);
            xfer(REGS[i], 1'b1, rng[7:0]);
            xfer(REGS[i], 1'b0, 8'h0);
            chk("count byte", q, {24'h0, rng[7:0]});
        end
        xfer(6'h21, 1'b1, 8'hFF);
        xfer(6'h21, 1'b0, 8'h0);
        chk("unmapped", q, 32'h0);
        // Pulse request in a pin mode is dropped; the request bit never reads back
        xfer(fsg_pkg::IDX_CTL, 1'b1, 8'h88);
        xfer(fsg_pkg::IDX_CTL, 1'b0, 8'h0);
        chk("request bit", q, 32'h80);
        $display("test registers done");
        for (int s = 4; s < 8; s++) begin
            rng = xorshift(rng);
            gen_case(4'(s), 1'b0, 8'h0, 8'(rng[2:0]), 8'h0, 8'(rng[10:8]), 2);
            gen_case(4'(s), 1'b1, rng[31:24], 8'h0, 8'h0, 8'(rng[18:16]), 2);
        end
        gen_case(4'h5, 1'b0, 8'h0, 8'h0, 8'h01, 8'h00, 2);
        gen_case(4'h6, 1'b1, 8'h00, 8'h00, 8'h01, 8'h00, 2);
        for (int p = 0; p < 4; p++) begin
            gen_case(4'(p), 1'b0, 8'h0, 8'h0, 8'h0, 8'h0, 2 * (p + 2));
        end
        shot(1'b0, 8'h03);
        xfer(fsg_pkg::IDX_CTL, 1'b1, 8'h44);
        repeat (3) @(posedge clk);
        chk("idle high", {31'h0, camera_trigger}, 32'h1);
        shot(1'b1, 8'h05);
        // Pin modes follow the chosen pin whatever the counters and enable say
        for (int n = 0; n < 8; n++) begin
            xfer(fsg_pkg::IDX_CTL, 1'b1, {4'(8 + n), 4'h3});
            repeat (2) begin
                rng = xorshift(rng);
                gpio_in <= rng[7:0];
                repeat (6) @(posedge clk);
                chk("pin pass", {31'h0, camera_trigger}, {31'h0, rng[n]});
            end
        end
        $display("test pin sources done");
        xfer(fsg_pkg::IDX_CTL, 1'b1, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
